// File: core/swc_pkg.sv
// Purpose: Shared constants and carrier types for the sleep and wake-up controller.
// Assumes: One core clock of 100 MHz; watchdog events arrive from their own oscillator.
// Notes: Register offsets are byte addresses on the plain register port.
package swc_pkg;
   // Register port widths
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   // Register offsets
   localparam logic [15:0] OPTION_CONTROL_OFS = 16'h0081;
   localparam logic [15:0] OPTION_CONTROL_ALT_OFS = 16'h0181;
   localparam logic [15:0] CONFIG_WORD_OFS = 16'h2007;
   localparam logic [15:0] STATUS_OFS = 16'h0003;
   localparam logic [15:0] WAKE_ENABLE_OFS = 16'h0090;
   localparam logic [15:0] WAKE_CAUSE_OFS = 16'h0091;
   // Reset values
   localparam logic [7:0] OPTION_CONTROL_RST = 8'hFF;
   localparam logic [7:0] WAKE_ENABLE_RST = 8'h00;
   localparam logic [7:0] CONFIG_WORD_DEFAULT = 8'h7F;
   // Field positions
   localparam int unsigned STATUS_PD_BIT = 3;
   localparam int unsigned STATUS_TO_BIT = 4;
   localparam int unsigned CFG_WDOG_EN_BIT = 3;
   localparam int unsigned OPT_PSA_BIT = 3;
   // Wake source indices
   localparam int unsigned WAKE_EDGE = 0;
   localparam int unsigned WAKE_PORTB = 1;
   localparam int unsigned WAKE_TMR1 = 2;
   localparam int unsigned WAKE_CAPT = 3;
   localparam int unsigned WAKE_SPEV = 4;
   localparam int unsigned WAKE_SSTP = 5;
   localparam int unsigned WAKE_SXFR = 6;
   localparam int unsigned WAKE_ADRC = 7;
   localparam int unsigned WAKE_LVD = 8;
   localparam int unsigned N_WAKE = 9;
   // Program flow
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   // Oscillator restart settle time
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned OSC_SETTLE_NS = 50;
   localparam int unsigned OSC_SETTLE_CYC = (OSC_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] OSC_SETTLE_CNT = 4'(OSC_SETTLE_CYC);

   typedef enum logic [2:0] {
      PWR_RUN,
      PWR_ENTER,
      PWR_SLEEP,
      PWR_SETTLE,
      PWR_RESUME
   } swc_pwr_e;

   // Wake requests from the interrupt sources
   typedef struct packed {
      logic [N_WAKE-1:0] flag;
   } swc_wake_s;

   // Core handshake toward the fetch logic
   typedef struct packed {
      logic resume;
      logic vector;
      logic [12:0] pc;
   } swc_resume_s;
endpackage : swc_pkg

// File: core/swc_sync.sv
// Purpose: Two flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes: Inputs are levels that stay stable for several core cycles.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/10ps
module swc_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Data
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule : swc_sync

// File: core/swc_top.sv
// Purpose: Power-down entry, wake-up and reset-cause flags for a small microcontroller.
// Assumes: The core pulses sleep_exec_i for the sleep instruction and keeps its state
//          while core_clk_en_o is low; this block itself stays clocked throughout.
// Notes: Watchdog, reset pin and interrupt flags come from other domains and are synchronised.
`timescale 1ns/10ps
module swc_top
   import swc_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic por_i,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   // Core
   input wire logic sleep_exec_i,
   input wire logic wdog_clear_exec_i,
   input wire logic global_irq_enable_i,
   input wire logic [12:0] pc_i,
   input wire logic [7:0] config_word_i,
   output logic core_clk_en_o,
   output logic osc_drv_en_o,
   output logic [12:0] fetch_addr_o,
   output logic fetch_req_o,
   output swc_resume_s resume_o,
   output logic sleep_nop_o,
   // Asynchronous events
   input wire logic external_reset_pin_n_i,
   input wire logic wdog_timeout_i,
   input wire swc_wake_s wake_flag_i,
   // Watchdog, reset, peripheral clock and pin hold control
   output logic wdog_clear_o,
   output logic device_reset_o,
   output logic periph_clk_en_o,
   output logic io_hold_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers
   localparam int unsigned SYNC_W = N_WAKE + 2;
   logic [SYNC_W-1:0] sync_in;
   logic [SYNC_W-1:0] sync_out;
   logic external_reset_pin_n_s;
   logic wdto_s;
   logic [N_WAKE-1:0] flag_s;

   // Pin is inverted into the synchroniser so its cleared stages read as released;
   // otherwise every reset release would show a false two-cycle pin reset
   assign sync_in = {!external_reset_pin_n_i, wdog_timeout_i, wake_flag_i.flag};

   swc_sync #(.W(SYNC_W)) u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .async_i(sync_in),
      .sync_o(sync_out)
   );

   assign external_reset_pin_n_s = !sync_out[SYNC_W-1];
   assign wdto_s = sync_out[SYNC_W-2];
   assign flag_s = sync_out[N_WAKE-1:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] option_control_q;
   logic [N_WAKE-1:0] wake_en_q;
   logic timeout_flag_q;
   logic power_down_flag_q;
   logic [1:0] wake_cause_q;
   logic [7:0] status_rd;
   logic wdto_d1_q;
   logic wdto_rise;
   logic wdog_en;
   logic [N_WAKE-1:0] wake_hit;
   logic irq_pending;
   swc_pwr_e state_q;
   logic [3:0] settle_q;
   logic [12:0] sleep_pc_q;
   logic sleep_taken;

   assign wdog_en = config_word_i[CFG_WDOG_EN_BIT];
   assign wdto_rise = wdto_s && !wdto_d1_q;

   // Clock-independent sources only; the wake-enable register holds one bit per source
   generate
      for (genvar i = 0; i < N_WAKE; i++) begin : g_wake
         assign wake_hit[i] = flag_s[i] && wake_en_q[i];
      end
   endgenerate
   assign irq_pending = |wake_hit;
   // A pending enabled interrupt turns the sleep instruction into a no-op
   assign sleep_taken = sleep_exec_i && !irq_pending && state_q == PWR_RUN;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         option_control_q <= OPTION_CONTROL_RST;
         wake_en_q <= '0;
      end else if (reg_wr_i) begin
         if (reg_addr_i == OPTION_CONTROL_OFS || reg_addr_i == OPTION_CONTROL_ALT_OFS) begin
            option_control_q <= reg_wdata_i;
         end
         if (reg_addr_i == WAKE_ENABLE_OFS) begin
            wake_en_q[7:0] <= reg_wdata_i;
         end
         if (reg_addr_i == WAKE_ENABLE_OFS + 16'h0002) begin
            wake_en_q[N_WAKE-1] <= reg_wdata_i[0];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         wdto_d1_q <= 1'b0;
      end else begin
         wdto_d1_q <= wdto_s;
      end
   end

   // Reset-cause flags: they survive a pin or watchdog reset; power-up and a watchdog clear preset them
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         timeout_flag_q <= 1'b1;
         power_down_flag_q <= 1'b1;
      end else if (por_i) begin
         timeout_flag_q <= 1'b1;
         power_down_flag_q <= 1'b1;
      end else if (wdto_rise && wdog_en) begin
         // A time-out and a sleep entry in the same cycle clear both flags
         timeout_flag_q <= 1'b0;
         if (sleep_taken) begin
            power_down_flag_q <= 1'b0;
         end
      end else if (sleep_taken) begin
         power_down_flag_q <= 1'b0;
         timeout_flag_q <= 1'b1;
      end else if (wdog_clear_exec_i) begin
         power_down_flag_q <= 1'b1;
         timeout_flag_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power state machine
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_q <= PWR_RUN;
         settle_q <= '0;
         sleep_pc_q <= '0;
         wake_cause_q <= 2'h0;
      end else if (!external_reset_pin_n_s) begin
         state_q <= PWR_RUN;
         settle_q <= '0;
         wake_cause_q <= 2'h1;
      end else begin
         case (state_q)
            PWR_RUN: begin
               if (sleep_taken) begin
                  sleep_pc_q <= 13'(pc_i + 13'h0001);
                  state_q <= PWR_ENTER;
               end
            end
            PWR_ENTER: begin
               // The sleep instruction completes before any wake is honoured
               state_q <= PWR_SLEEP;
            end
            PWR_SLEEP: begin
               if (wdto_rise && wdog_en) begin
                  wake_cause_q <= 2'h2;
                  settle_q <= OSC_SETTLE_CNT;
                  state_q <= PWR_SETTLE;
               end else if (irq_pending) begin
                  wake_cause_q <= 2'h3;
                  settle_q <= OSC_SETTLE_CNT;
                  state_q <= PWR_SETTLE;
               end
            end
            PWR_SETTLE: begin
               if (settle_q <= 4'h1) begin
                  state_q <= PWR_RESUME;
               end else begin
                  settle_q <= settle_q - 4'h1;
               end
            end
            PWR_RESUME: begin
               state_q <= PWR_RUN;
            end
            default: begin
               state_q <= PWR_RUN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Core-facing outputs
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         core_clk_en_o <= 1'b1;
         osc_drv_en_o <= 1'b1;
         periph_clk_en_o <= 1'b1;
         io_hold_o <= 1'b0;
      end else begin
         // Clock gate and oscillator follow the state one cycle later
         core_clk_en_o <= !(state_q == PWR_ENTER || state_q == PWR_SLEEP
                            || state_q == PWR_SETTLE);
         osc_drv_en_o <= !(state_q == PWR_ENTER || state_q == PWR_SLEEP);
         // Gating peripheral clocks keeps clocked sources from raising flags
         periph_clk_en_o <= !(state_q == PWR_ENTER || state_q == PWR_SLEEP);
         // Pin latches and direction bits are frozen, not reset
         io_hold_o <= state_q == PWR_ENTER || state_q == PWR_SLEEP
                      || state_q == PWR_SETTLE;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         fetch_addr_o <= '0;
         fetch_req_o <= 1'b0;
         resume_o <= '0;
         sleep_nop_o <= 1'b0;
      end else begin
         fetch_req_o <= sleep_taken;
         if (sleep_taken) begin
            fetch_addr_o <= 13'(pc_i + 13'h0001);
         end
         sleep_nop_o <= sleep_exec_i && !sleep_taken;
         resume_o.resume <= state_q == PWR_RESUME && external_reset_pin_n_s;
         resume_o.pc <= sleep_pc_q;
         // Vector only for an interrupt wake with global enable set; the core runs the
         // prefetched instruction first, then branches to the vector
         resume_o.vector <= state_q == PWR_RESUME && wake_cause_q == 2'h3 && external_reset_pin_n_s
                            && global_irq_enable_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         wdog_clear_o <= 1'b0;
         device_reset_o <= 1'b0;
      end else begin
         // No clear when sleep degenerates into a no-op
         wdog_clear_o <= wdog_en && (sleep_taken || wdog_clear_exec_i);
         device_reset_o <= !external_reset_pin_n_s
                           || (wdto_rise && wdog_en && state_q == PWR_RUN
                               && !sleep_taken);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register read
   always_comb begin
      status_rd = 8'h00;
      status_rd[STATUS_PD_BIT] = power_down_flag_q;
      status_rd[STATUS_TO_BIT] = timeout_flag_q;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            OPTION_CONTROL_OFS, OPTION_CONTROL_ALT_OFS: reg_rdata_o <= option_control_q;
            CONFIG_WORD_OFS: reg_rdata_o <= config_word_i;
            STATUS_OFS: reg_rdata_o <= status_rd;
            WAKE_ENABLE_OFS: reg_rdata_o <= wake_en_q[7:0];
            WAKE_ENABLE_OFS + 16'h0002: reg_rdata_o <= {7'h00, wake_en_q[N_WAKE-1]};
            WAKE_CAUSE_OFS: reg_rdata_o <= {6'h00, wake_cause_q};
            default: reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end
endmodule : swc_top

// File: verification/swc_assertions.sv
// Purpose: Port-level checks for the sleep and wake-up controller.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Checks tie an output to its cause at the inputs or to another output.
`timescale 1ns/10ps
module swc_assertions
   import swc_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Inputs watched
   input wire logic sleep_exec_i,
   input wire logic global_irq_enable_i,
   input wire logic external_reset_pin_n_i,
   input wire logic [12:0] pc_i,
   input wire logic [7:0] config_word_i,
   // Outputs watched
   input wire logic fetch_req_o,
   input wire logic [12:0] fetch_addr_o,
   input wire logic sleep_nop_o,
   input wire logic wdog_clear_o,
   input wire logic core_clk_en_o,
   input wire logic osc_drv_en_o,
   input wire logic periph_clk_en_o,
   input wire logic io_hold_o,
   input wire logic device_reset_o,
   input wire swc_resume_s resume_o
);
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_fetch_next: assert property (fetch_req_o |-> fetch_addr_o == $past(pc_i) + 13'h1)
      else $error("fetch address is not the sleep address plus one");
   a_sleep_cause: assert property ((fetch_req_o || sleep_nop_o) |->
      $past(sleep_exec_i) && !(fetch_req_o && sleep_nop_o))
      else $error("sleep outcome without a sleep or with both outcomes");
   a_gate_after: assert property (fetch_req_o |=> !core_clk_en_o && !osc_drv_en_o && io_hold_o)
      else $error("clocks not stopped one cycle after sleep entry");
   a_hold_asleep: assert property (!core_clk_en_o |-> io_hold_o)
      else $error("pins released while core clock is stopped");
   a_periph_off: assert property (!osc_drv_en_o |-> !periph_clk_en_o)
      else $error("peripheral clock runs with oscillator off");
   a_wdog_cfg: assert property (wdog_clear_o |-> config_word_i[CFG_WDOG_EN_BIT])
      else $error("watchdog cleared while disabled");
   a_resume_pc: assert property (resume_o.resume |-> resume_o.pc == fetch_addr_o)
      else $error("resume address differs from prefetch address");
   a_vector_gie: assert property (resume_o.vector |-> resume_o.resume && global_irq_enable_i)
      else $error("vector without resume or with global enable clear");
   a_resume_clk: assert property (resume_o.resume |-> ##[0:1] core_clk_en_o)
      else $error("core clock not back on resume");
   a_pin_reset: assert property (!external_reset_pin_n_i [*4] |-> device_reset_o)
      else $error("reset pin low without device reset");
endmodule : swc_assertions
bind swc_top swc_assertions i_swc_assertions (.*);

// File: verification/swc_core_model.sv
// Purpose: Core-side model issuing watchdog clear and sleep instructions.
// Assumes: go_i is a one-cycle request from the bench.
// Notes: A stopped core clock blocks new strobes from the model rather than holding them.
`timescale 1ns/10ps
module swc_core_model (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Bench request and clock gate
   input wire logic go_i,
   input wire logic core_clk_en_i,
   input wire logic [12:0] pc_base_i,
   // Instruction strobes
   output logic wdog_clear_exec_o,
   output logic sleep_exec_o,
   output logic [12:0] pc_o
);
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         wdog_clear_exec_o <= 1'b0;
         sleep_exec_o <= 1'b0;
      end else begin
         // Clear first so a sleep that degrades to a no-op still kicks the dog
         wdog_clear_exec_o <= go_i & core_clk_en_i;
         // Next instruction is the sleep, nothing else is issued
         sleep_exec_o <= wdog_clear_exec_o & core_clk_en_i;
      end
   end
   // Address is only meaningful with the sleep strobe, so it is scrambled otherwise
   assign pc_o = sleep_exec_o ? pc_base_i : ~pc_base_i;
endmodule : swc_core_model

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the sleep and wake-up controller.
// Assumes: Wake events are levels held well past the synchroniser.
// Notes: Core model issues watchdog clear then sleep on each request.
`timescale 1ns/10ps
module tb_top;
   import swc_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic por_i = 1'b1;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic global_irq_enable_i = 1'b0;
   logic [7:0] config_word_i = CONFIG_WORD_DEFAULT;
   logic external_reset_pin_n_i = 1'b1;
   logic wdog_timeout_i = 1'b0;
   swc_wake_s wake_flag_i = 9'h000;
   logic go = 1'b0;
   logic [12:0] pc_base = 13'h0123;
   logic [12:0] pc_i, fetch_addr_o;
   logic [7:0] reg_rdata_o;
   logic sleep_exec_i, wdog_clear_exec_i, core_clk_en_o, osc_drv_en_o, fetch_req_o;
   logic sleep_nop_o, wdog_clear_o, device_reset_o, periph_clk_en_o, io_hold_o;
   swc_resume_s resume_o;
   int n_mismatch = 0;
   int samples_checked = 0;
   swc_top i_swc_top (.*);
   swc_core_model i_swc_core_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .go_i(go),
      .core_clk_en_i(core_clk_en_o), .pc_base_i(pc_base),
      .wdog_clear_exec_o(wdog_clear_exec_i), .sleep_exec_o(sleep_exec_i), .pc_o(pc_i));
   initial forever #5 mclk_i = ~mclk_i;
   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(reg_rdata_o, e);
   endtask : rd
   // Sel 0 resume, 1 sleep outcome, 2 device reset
   task automatic wait_on(input int sel, input logic must, output logic hit);
      hit = 1'b0;
      for (int i = 0; i < 40 && hit !== 1'b1; i++) begin
         @(posedge mclk_i);
         #1;
         hit = (sel == 0) ? resume_o.resume
               : (sel == 1) ? (fetch_req_o | sleep_nop_o) : device_reset_o;
      end
      if (must) begin
         chk(hit, 1'b1);
         if (hit !== 1'b1) finish_test();
      end
   endtask : wait_on
   task automatic sleep_go;
      logic hit;
      @(posedge mclk_i);
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      wait_on(1, 1'b1, hit);
   endtask : sleep_go
   task automatic set_ev(input logic [8:0] f, input logic wd, input logic pin_n);
      @(posedge mclk_i);
      wake_flag_i <= f;
      wdog_timeout_i <= wd;
      external_reset_pin_n_i <= pin_n;
   endtask : set_ev
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd(STATUS_OFS, 8'h18);
      rd(WAKE_CAUSE_OFS, 8'h00);
      chk(device_reset_o, 1'b0);
      rd(OPTION_CONTROL_OFS, OPTION_CONTROL_RST);
      wr(OPTION_CONTROL_OFS, 8'h5A);
      rd(OPTION_CONTROL_ALT_OFS, 8'h5A);
      wr(CONFIG_WORD_OFS, 8'h00);
      rd(CONFIG_WORD_OFS, CONFIG_WORD_DEFAULT);
      rd(16'h0055, 8'h00);
   endtask : t_regs
   task automatic t_irq(input int s, input logic global_irq_enable);
      logic hit;
      wr(WAKE_ENABLE_OFS, 8'(9'h001 << s));
      wr(16'h0092, {7'h00, s == 8});
      @(posedge mclk_i);
      global_irq_enable_i <= global_irq_enable;
      sleep_go();
      chk({fetch_req_o, wdog_clear_o}, 2'b11);
      chk(fetch_addr_o, pc_base + 13'h0001);
      rd(STATUS_OFS, 8'h10);
      chk({core_clk_en_o, osc_drv_en_o, io_hold_o}, 3'b001);
      chk(periph_clk_en_o, 1'b0);
      set_ev(9'h001 << s, 1'b0, 1'b1);
      wait_on(0, 1'b1, hit);
      chk(resume_o.vector, global_irq_enable);
      chk(resume_o.pc, pc_base + 13'h0001);
      set_ev(9'h000, 1'b0, 1'b1);
      repeat (4) @(posedge mclk_i);
   endtask : t_irq
   task automatic t_wdog_sleep;
      logic hit;
      wr(WAKE_ENABLE_OFS, 8'h00);
      wr(16'h0092, 8'h00);
      sleep_go();
      set_ev(9'h1FF, 1'b0, 1'b1);
      wait_on(0, 1'b0, hit);
      chk(hit, 1'b0);
      set_ev(9'h1FF, 1'b1, 1'b1);
      wait_on(0, 1'b1, hit);
      chk({resume_o.vector, device_reset_o}, 2'b00);
      rd(STATUS_OFS, 8'h00);
      rd(WAKE_CAUSE_OFS, 8'h02);
      set_ev(9'h000, 1'b0, 1'b1);
      repeat (4) @(posedge mclk_i);
   endtask : t_wdog_sleep
   task automatic t_pending;
      wr(WAKE_ENABLE_OFS, 8'h02);
      set_ev(9'h002, 1'b0, 1'b1);
      repeat (4) @(posedge mclk_i);
      sleep_go();
      chk({sleep_nop_o, wdog_clear_o}, 2'b10);
      rd(STATUS_OFS, 8'h18);
      chk(core_clk_en_o, 1'b1);
      set_ev(9'h000, 1'b0, 1'b1);
      repeat (4) @(posedge mclk_i);
   endtask : t_pending
   task automatic t_wdog_awake;
      logic hit;
      set_ev(9'h000, 1'b1, 1'b1);
      wait_on(2, 1'b1, hit);
      rd(STATUS_OFS, 8'h08);
      set_ev(9'h000, 1'b0, 1'b1);
      repeat (4) @(posedge mclk_i);
   endtask : t_wdog_awake
   task automatic t_pin;
      logic hit;
      sleep_go();
      set_ev(9'h000, 1'b0, 1'b0);
      wait_on(2, 1'b1, hit);
      rd(WAKE_CAUSE_OFS, 8'h01);
      chk({core_clk_en_o, device_reset_o}, 2'b11);
      set_ev(9'h000, 1'b0, 1'b1);
      repeat (4) @(posedge mclk_i);
   endtask : t_pin
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      por_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      t_regs();
      for (int s = 0; s < N_WAKE; s++) begin
         t_irq(s, s[0]);
      end
      t_wdog_sleep();
      t_pending();
      t_wdog_awake();
      t_pin();
      finish_test();
   end
endmodule : tb_top
